//--- crtu_channel.sv
// One 16-bit reloading counter channel of the timer unit.
// Assumes count ticks and events are one-cycle pulses on hclk.
`timescale 1ns/1ps
`include "crtu_map.svh"

module crtu_channel (
    input  wire logic                   hclk,       // System clock
    input  wire logic                   hresetn,    // Async reset, active low
    input  wire logic [`CRTU_CFG_W-1:0] cfg,        // Mode register
    input  wire logic                   start,      // Count-start flag
    input  wire logic                   up_flag,    // Software direction
    input  wire logic                   dir_pin,    // Pin direction level
    input  wire logic [2:0]             src_tick,   // Prescaled clock pulses
    input  wire logic [2:0]             ev_tick,    // B-group overflow and neighbour wrap pulses
    input  wire logic                   wr_en,      // Count register write
    input  wire logic [`CRTU_CNT_W-1:0] wr_data,    // Written value
    output logic      [`CRTU_CNT_W-1:0] count_val,  // Current count
    output logic                        irq,        // Wrap pulse
    output logic                        tgl         // Pulse output level
);
    import crtu_pkg::*;

    crtu_chan_st_t s_reg;
    crtu_chan_st_t s_next;
    crtu_mode_t    mode;
    logic          tick;
    logic          up;
    logic          wrap;

    function automatic logic pick(input logic [2:0] v, input logic [1:0] sel);
        pick = (sel == 2'h3) ? 1'b0 : v[sel];
    endfunction : pick

    always_comb begin
        s_next = s_reg;
        s_next.irq = 1'b0;
        mode = crtu_mode_t'(cfg[`CRTU_F_MODE]);
        tick = (mode == CRTU_MODE_EVENT) ? pick(ev_tick, cfg[`CRTU_F_SRC])
                                         : pick(src_tick, cfg[`CRTU_F_SRC]);
        up = (mode == CRTU_MODE_EVENT) && (cfg[`CRTU_F_DIRPIN] ? dir_pin : up_flag);
        wrap = up ? (s_reg.cnt == `CRTU_CNT_MAX) : (s_reg.cnt == `CRTU_CNT_ZERO);
        if (!start) begin
            s_next.halted = 1'b0;
        end
        // Stopped channel holds count, raises nothing
        if (start && tick && !s_reg.halted) begin
            if (wrap) begin
                s_next.irq = 1'b1;
                if (cfg[`CRTU_F_PULSE]) begin
                    s_next.tgl = ~s_reg.tgl;
                end
                if (mode == CRTU_MODE_EVENT && cfg[`CRTU_F_FREE]) begin
                    s_next.cnt = up ? `CRTU_CNT_ZERO : `CRTU_CNT_MAX;
                end else begin
                    s_next.cnt = s_reg.reload;
                end
                if (mode == CRTU_MODE_ONESHOT) begin
                    s_next.halted = 1'b1;
                end
            end else if (up) begin
                s_next.cnt = s_reg.cnt + 16'h0001;
            end else begin
                s_next.cnt = s_reg.cnt - 16'h0001;
            end
        end
        if (wr_en) begin
            s_next.reload = wr_data;
            if (!start) begin
                s_next.cnt = wr_data;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign count_val = s_reg.cnt;
    assign irq       = s_reg.irq;
    assign tgl       = s_reg.tgl;

endmodule : crtu_channel

//--- crtu_chk.sv
// Checker for the timer unit top: bus handshake and quiet channels.
// Assumes hready is tied to hreadyout and one bus master.
`timescale 1ns/1ps
module crtu_chk (
    input wire logic        hclk,                        // Clock
    input wire logic        hresetn,                     // Reset, active low
    input wire logic        hsel,                        // Select
    input wire logic [1:0]  htrans,                      // Transfer type
    input wire logic        hwrite,                      // Write
    input wire logic        hready,                      // Bus ready
    input wire logic        hreadyout,                   // Slave ready
    input wire logic [31:0] hrdata,                      // Read data
    input wire logic        hresp,                       // Response
    input wire logic        channel_two_output_pin_o,    // Pin 2 level
    input wire logic        channel_two_output_pin_oe,   // Pin 2 enable
    input wire logic        channel_three_output_pin_o,  // Pin 3 level
    input wire logic        channel_three_output_pin_oe, // Pin 3 enable
    input wire logic [4:0]  channel_irq                  // Wrap pulses
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       take;
    logic [3:0] wr_hist;
    logic       any_wr;
    assign take = hsel && hready && htrans[1];
    // Oe may only move a few cycles after a register write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_hist <= 4'h0;
            any_wr  <= 1'b0;
        end else begin
            wr_hist <= {wr_hist[2:0], take && hwrite};
            any_wr  <= any_wr | (take && hwrite);
        end
    end
    chk_ready_drop: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("ready not low for one cycle");
    chk_ready_idle: assert property (!take |=> hreadyout)
        else $error("ready low without transfer");
    chk_rdata_hold: assert property (!(take && !hwrite) |=> ##1 $stable(hrdata))
        else $error("read data moved without read");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_quiet_boot: assert property (!any_wr |-> channel_irq == 5'h00)
        else $error("request before any start");
    chk_pin_still: assert property (!any_wr |-> !channel_two_output_pin_o && !channel_three_output_pin_o)
        else $error("pin level moved before setup");
    chk_oe2_cause: assert property ($changed(channel_two_output_pin_oe) |-> |wr_hist)
        else $error("pin 2 enable moved without write");
    chk_oe3_cause: assert property ($changed(channel_three_output_pin_oe) |-> |wr_hist)
        else $error("pin 3 enable moved without write");
    cover property (take && hwrite);
    cover property (channel_irq[0]);
    cover property ($changed(channel_two_output_pin_o));
endmodule : crtu_chk

//--- crtu_far_model.sv
// Far side of the timer unit: b-group overflow source and pin drivers.
// Assumes requests arrive from the bench right after a rising edge.
`timescale 1ns/1ps
module crtu_far_model (
    input  wire logic       hclk,     // Clock
    input  wire logic       hresetn,  // Reset, active low
    input  wire logic [3:0] burst,    // Events to send
    input  wire logic       load,     // Start a burst
    output logic            ev_pulse, // One-cycle overflow pulse
    output logic            busy,     // Burst in progress
    input  wire logic       dir_lvl,  // Level driven when pin released
    input  wire logic       o2,       // Unit drive level, pin 2
    input  wire logic       oe2,      // Unit drive enable, pin 2
    input  wire logic       o3,       // Unit drive level, pin 3
    input  wire logic       oe3,      // Unit drive enable, pin 3
    output logic            pin2,     // Resolved pin 2
    output logic            pin3      // Resolved pin 3
);
    logic [4:0] left;
    // Pulses spaced by one idle cycle, as a real overflow would be
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left     <= 5'h00;
            ev_pulse <= 1'b0;
        end else begin
            ev_pulse <= !load && left != 5'h00 && left[0];
            if (load) left <= {burst, 1'b0};
            else if (left != 5'h00) left <= left - 5'h01;
        end
    end
    assign busy = left != 5'h00 || ev_pulse;
    assign pin2 = oe2 ? o2 : dir_lvl;
    assign pin3 = oe3 ? o3 : dir_lvl;
endmodule : crtu_far_model

//--- crtu_map.svh
// Register offsets, field positions and counts of the reload timer unit.
// Included by the package, the channel, the top and the bench; definitions only.
`ifndef CRTU_MAP_SVH
`define CRTU_MAP_SVH

`define CRTU_NUM_CH      5
`define CRTU_CNT_W       16
`define CRTU_CFG_W       8

// Byte offsets of the word registers on the register bus
`define CRTU_OFF_START   8'h00
`define CRTU_OFF_UPDOWN  8'h04
`define CRTU_OFF_PORT    8'h08
`define CRTU_OFF_MODE    8'h10
`define CRTU_OFF_COUNT   8'h30
`define CRTU_BAD_IDX     3'h7

// Fields of a channel mode register
`define CRTU_F_MODE      1:0
`define CRTU_F_PULSE     2
`define CRTU_F_SRC       4:3
`define CRTU_F_FREE      5
`define CRTU_F_DIRPIN    6

// Port register fields
`define CRTU_F_PDATA     1:0
`define CRTU_F_PDIR      3:2

// Counter limits and prescaler terminal values
`define CRTU_CNT_ZERO    16'h0000
`define CRTU_CNT_MAX     16'hffff
`define CRTU_DIV8_MASK   5'h07
`define CRTU_DIV32_LAST  5'h1f

`define CRTU_RESP_OKAY   1'b0

`endif

//--- crtu_pkg.sv
// Types shared by the reload timer unit modules.
// Assumes crtu_map.svh is on the include path.
`include "crtu_map.svh"

package crtu_pkg;

    typedef enum logic [1:0] {
        CRTU_MODE_INTERVAL = 2'h0,
        CRTU_MODE_EVENT    = 2'h1,
        CRTU_MODE_ONESHOT  = 2'h2,
        CRTU_MODE_PWM      = 2'h3
    } crtu_mode_t;

    typedef struct packed {
        logic [`CRTU_CNT_W-1:0] cnt;
        logic [`CRTU_CNT_W-1:0] reload;
        logic                   irq;
        logic                   tgl;
        logic                   halted;
    } crtu_chan_st_t;

    typedef struct packed {
        logic [`CRTU_NUM_CH-1:0]                  start;
        logic [`CRTU_NUM_CH-1:0]                  updown;
        logic [3:0]                               port;
        logic [`CRTU_NUM_CH-1:0][`CRTU_CFG_W-1:0] mode;
        logic                                     pend;
        logic                                     pend_write;
        logic [7:0]                               addr;
        logic                                     ready;
        logic [31:0]                              rdata;
        logic [1:0][2:0]                          sync;
        logic [1:0]                               lvl;
        logic [1:0]                               pin_out;
        logic [1:0]                               pin_oe;
        logic [4:0]                               pre;
        logic                                     tick8;
        logic                                     tick32;
    } crtu_top_st_t;

endpackage : crtu_pkg

//--- crtu_top.sv
// Cascadable reload timer unit: five counter channels behind an AHB-Lite slave.
// Assumes a single AHB-Lite master; pin inputs are asynchronous to hclk;
// the b-group overflow input is a one-cycle pulse on hclk.
`timescale 1ns/1ps
`include "crtu_map.svh"

// Summary of operation
// - Five independent channels, each a 16-bit counter with 16-bit reload register.
// - Mode register bits 0 and 1 select interval, event or one-shot; value 3 (PWM) runs as interval mode.
// - One-shot mode reloads and halts the counter at its first underflow.
// - Interval mode counts undivided, eighth or thirty-second prescaled clock.
// - Interval mode counts down and reloads on each underflow.
// - Interval mode with reload n underflows every n+1 source pulses.
// - Channel counts only while its count-start flag is one.
// - Interval mode raises the interrupt request on every underflow.
// - Reading the count register returns the current counter value.
// - Write while stopped updates both reload register and counter.
// - Write while counting updates only the reload register.
// - Interval mode with pulse output inverts the output pin each underflow.
// - Event mode counts wraps of b-group third timer or two neighbours.
// - Event direction comes from the up/down flag or the direction pin.
// - Event mode without free-run reloads on every overflow or underflow.
// - Event wrap every ffff-n+1 events up, n+1 events down.
// - Event mode raises the interrupt request on every wrap.
// - Event mode with free-run wraps without reloading.
// - Event mode with pulse output inverts the output pin each wrap, unless the pin is the direction input.
// - Channels 2 and 3 pin: general port, pulse output or direction input.
module crtu_top (
    input  wire logic        hclk,                        // System clock, 125 MHz
    input  wire logic        hresetn,                     // Async reset, active low
    input  wire logic        hsel,                        // Slave select
    input  wire logic [31:0] haddr,                       // Byte address
    input  wire logic [1:0]  htrans,                      // Transfer type
    input  wire logic        hwrite,                      // Write transfer
    input  wire logic [2:0]  hsize,                       // Word only
    input  wire logic [31:0] hwdata,                      // Write data
    input  wire logic        hready,                      // Bus ready
    output logic             hreadyout,                   // Slave ready
    output logic [31:0]      hrdata,                      // Read data
    output logic             hresp,                       // Always OKAY
    input  wire logic        b_group_third_timer,         // Overflow pulse in
    input  wire logic        channel_two_output_pin_i,    // Pin level in
    output logic             channel_two_output_pin_o,    // Pin level out
    output logic             channel_two_output_pin_oe,   // Pin drive enable
    input  wire logic        channel_three_output_pin_i,  // Pin level in
    output logic             channel_three_output_pin_o,  // Pin level out
    output logic             channel_three_output_pin_oe, // Pin drive enable
    output logic [4:0]       channel_irq                  // Wrap request pulses
);
    import crtu_pkg::*;

    // ****************************************
    // State and channel wiring
    // ****************************************

    crtu_top_st_t                             s_reg;
    crtu_top_st_t                             s_next;
    logic [`CRTU_NUM_CH-1:0][`CRTU_CNT_W-1:0] cnt_bus;
    logic [`CRTU_NUM_CH-1:0]                  wrap_bus;
    logic [`CRTU_NUM_CH-1:0]                  tgl_bus;
    logic [`CRTU_NUM_CH-1:0]                  wr_cnt;
    logic [`CRTU_NUM_CH-1:0]                  dir_lvl;
    logic [1:0]                               pin_in;
    logic [2:0]                               idx_mode;
    logic [2:0]                               idx_cnt;

    assign pin_in = {channel_three_output_pin_i, channel_two_output_pin_i};

    // Index of a per-channel register, or the bad index when unmapped
    function automatic logic [2:0] chan_index(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] off;
        off = a - base;
        if (a >= base && off[1:0] == 2'h0 && off[7:2] < 6'(`CRTU_NUM_CH)) begin
            chan_index = off[4:2];
        end else begin
            chan_index = `CRTU_BAD_IDX;
        end
    endfunction : chan_index

    // ****************************************
    // Next-state logic
    // ****************************************

    always_comb begin
        s_next = s_reg;
        wr_cnt = '0;
        idx_mode = chan_index(s_reg.addr, `CRTU_OFF_MODE);
        idx_cnt = chan_index(s_reg.addr, `CRTU_OFF_COUNT);

        // Pin synchronisers: level changes once second and third stage agree
        for (int p = 0; p < 2; p++) begin
            s_next.sync[p] = {s_reg.sync[p][1:0], pin_in[p]};
            if (s_reg.sync[p][1] == s_reg.sync[p][2]) begin
                s_next.lvl[p] = s_reg.sync[p][2];
            end
        end

        // Shared prescaler for the eighth and thirty-second clocks
        s_next.pre = s_reg.pre + 5'h01;
        s_next.tick8 = (s_reg.pre & `CRTU_DIV8_MASK) == `CRTU_DIV8_MASK;
        s_next.tick32 = s_reg.pre == `CRTU_DIV32_LAST;

        // Bus: one wait state per transfer so read data comes from a flop
        if (s_reg.pend) begin
            s_next.pend = 1'b0;
            s_next.ready = 1'b1;
            if (s_reg.pend_write) begin
                if (s_reg.addr == `CRTU_OFF_START) begin
                    s_next.start = hwdata[`CRTU_NUM_CH-1:0];
                end else if (s_reg.addr == `CRTU_OFF_UPDOWN) begin
                    s_next.updown = hwdata[`CRTU_NUM_CH-1:0];
                end else if (s_reg.addr == `CRTU_OFF_PORT) begin
                    s_next.port = hwdata[3:0];
                end else if (idx_mode != `CRTU_BAD_IDX) begin
                    s_next.mode[idx_mode] = hwdata[`CRTU_CFG_W-1:0];
                end else if (idx_cnt != `CRTU_BAD_IDX) begin
                    wr_cnt[idx_cnt] = 1'b1;
                end
            end else begin
                s_next.rdata = 32'h0000_0000;
                if (s_reg.addr == `CRTU_OFF_START) begin
                    s_next.rdata[`CRTU_NUM_CH-1:0] = s_reg.start;
                end else if (s_reg.addr == `CRTU_OFF_UPDOWN) begin
                    s_next.rdata[`CRTU_NUM_CH-1:0] = s_reg.updown;
                end else if (s_reg.addr == `CRTU_OFF_PORT) begin
                    s_next.rdata[5:0] = {s_reg.lvl, s_reg.port};
                end else if (idx_mode != `CRTU_BAD_IDX) begin
                    s_next.rdata[`CRTU_CFG_W-1:0] = s_reg.mode[idx_mode];
                end else if (idx_cnt != `CRTU_BAD_IDX) begin
                    s_next.rdata[`CRTU_CNT_W-1:0] = cnt_bus[idx_cnt];
                end
            end
        end else if (hsel && hready && htrans[1]) begin
            s_next.pend = 1'b1;
            s_next.pend_write = hwrite;
            s_next.addr = haddr[7:0];
            s_next.ready = 1'b0;
        end

        // Pins of channels 2 and 3
        for (int p = 0; p < 2; p++) begin
            if (s_reg.mode[p+2][`CRTU_F_DIRPIN]
                && s_reg.mode[p+2][`CRTU_F_MODE] == CRTU_MODE_EVENT) begin
                s_next.pin_oe[p] = 1'b0;
                s_next.pin_out[p] = 1'b0;
            end else if (s_reg.mode[p+2][`CRTU_F_PULSE]) begin
                s_next.pin_oe[p] = 1'b1;
                s_next.pin_out[p] = tgl_bus[p+2];
            end else begin
                s_next.pin_oe[p] = s_reg.port[p+2];
                s_next.pin_out[p] = s_reg.port[p];
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
            s_reg.ready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Channels
    // ****************************************

    // Only channels 2 and 3 own a pin; the rest see their flag on both inputs
    always_comb begin
        dir_lvl = s_reg.updown;
        dir_lvl[2] = s_reg.lvl[0];
        dir_lvl[3] = s_reg.lvl[1];
    end

    genvar gi;
    generate
        for (gi = 0; gi < `CRTU_NUM_CH; gi++) begin : g_ch
            localparam int NB1 = (gi + `CRTU_NUM_CH - 1) % `CRTU_NUM_CH;
            localparam int NB2 = (gi + 1) % `CRTU_NUM_CH;
            // Neighbour wraps come from flops, so the ring forms no loop
            crtu_channel u_ch (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .cfg       (s_reg.mode[gi]),
                .start     (s_reg.start[gi]),
                .up_flag   (s_reg.updown[gi]),
                .dir_pin   (dir_lvl[gi]),
                .src_tick  ({s_reg.tick32, s_reg.tick8, 1'b1}),
                .ev_tick   ({wrap_bus[NB2], wrap_bus[NB1], b_group_third_timer}),
                .wr_en     (wr_cnt[gi]),
                .wr_data   (hwdata[`CRTU_CNT_W-1:0]),
                .count_val (cnt_bus[gi]),
                .irq       (wrap_bus[gi]),
                .tgl       (tgl_bus[gi])
            );
        end
    endgenerate

    // ****************************************
    // Outputs
    // ****************************************

    assign hreadyout                   = s_reg.ready;
    assign hrdata                      = s_reg.rdata;
    assign hresp                       = `CRTU_RESP_OKAY;
    assign channel_two_output_pin_o    = s_reg.pin_out[0];
    assign channel_two_output_pin_oe   = s_reg.pin_oe[0];
    assign channel_three_output_pin_o  = s_reg.pin_out[1];
    assign channel_three_output_pin_oe = s_reg.pin_oe[1];
    assign channel_irq                 = wrap_bus;

endmodule : crtu_top

//--- crtu_top_tb.sv
// Self-checking bench for the timer unit top over AHB-Lite.
// Assumes crtu_map.svh on the include path and the far-side model.
`timescale 1ns/1ps
`include "crtu_map.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module crtu_top_tb;
    localparam logic [31:0] A_START = 32'(`CRTU_OFF_START);
    localparam logic [31:0] A_UD    = 32'(`CRTU_OFF_UPDOWN);
    localparam logic [31:0] A_PORT  = 32'(`CRTU_OFF_PORT);
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, load = 0, dir_lvl = 0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [3:0]  burst = 4'h0;
    logic        hreadyout, hresp, ev, busy, o2, oe2, o3, oe3, pin2, pin3;
    logic [4:0]  channel_irq;
    logic [15:0] ic [5] = '{default: 16'h0};
    int          n_errors = 0, samples_checked = 0;
    always #4 hclk = ~hclk;
    always @(posedge hclk) for (int i = 0; i < 5; i++) ic[i] <= ic[i] + 16'(channel_irq[i]);
    crtu_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .b_group_third_timer(ev),
        .channel_two_output_pin_i(pin2), .channel_two_output_pin_o(o2), .channel_two_output_pin_oe(oe2),
        .channel_three_output_pin_i(pin3), .channel_three_output_pin_o(o3),
        .channel_three_output_pin_oe(oe3), .channel_irq);
    crtu_far_model i_far (.hclk, .hresetn, .burst, .load, .ev_pulse(ev), .busy, .dir_lvl,
        .o2, .oe2, .o3, .oe3, .pin2, .pin3);
    function automatic logic [31:0] cnt_a(input int i);
        return 32'(`CRTU_OFF_COUNT) + 32'(4 * i);
    endfunction : cnt_a
    function automatic logic [31:0] mode_a(input int i);
        return 32'(`CRTU_OFF_MODE) + 32'(4 * i);
    endfunction : mode_a
    task wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task to_out;
        n_errors++;
        wrap_up;
    endtask : to_out
    // ****************************************
    // Bus cycles and waits
    // ****************************************
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2;
        k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
        r = hrdata;
        if (k >= 100) to_out;
    endtask : bus
    task automatic w(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : w
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask : rd
    task automatic wait_irq(input int ch, output int k);
        k = 0;
        do begin @(negedge hclk); k++; end while (channel_irq[ch] !== 1'b1 && k < 400);
        if (k >= 400) to_out;
    endtask : wait_irq
    task automatic period(input int ch, input int exp);
        int c;
        wait_irq(ch, c);
        c = 0;
        do begin @(negedge hclk); c++; end while (channel_irq[ch] !== 1'b1 && c < 400);
        `CHK(c, exp)
    endtask : period
    task automatic fire(input logic [3:0] n);
        int k;
        @(posedge hclk);
        burst <= n; load <= 1'b1;
        @(posedge hclk);
        load <= 1'b0;
        k = 0;
        do begin @(posedge hclk); k++; end while (busy !== 1'b0 && k < 50);
        if (k >= 50) to_out;
        repeat (4) @(posedge hclk);
    endtask : fire
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_interval;
        logic [31:0] r;
        logic [15:0] s;
        w(cnt_a(0), 32'h2);
        rd(cnt_a(0), r);
        `CHK(r, 32'h2)
        for (int i = 0; i < 3; i++) begin
            w(mode_a(0), 32'(i) << 3);
            w(A_START, 32'h1);
            period(0, 3 * (i == 0 ? 1 : i == 1 ? 8 : 32));
            w(A_START, 32'h0);
            w(cnt_a(0), 32'h2);
        end
        w(mode_a(0), 32'h2);
        s = ic[0];
        w(A_START, 32'h1);
        repeat (30) @(posedge hclk);
        `CHK(ic[0] - s, 16'h1)
        w(A_START, 32'h0);
        $display("interval test done");
    endtask : t_interval
    task automatic t_run;
        logic [31:0] r, r2;
        logic [15:0] s;
        int          k;
        w(mode_a(0), 32'h0);
        w(cnt_a(0), 32'h2);
        w(A_START, 32'h1);
        w(cnt_a(0), 32'h5);
        wait_irq(0, k);
        `CHK(k <= 4, 1'b1)
        period(0, 6);
        w(A_START, 32'h0);
        rd(cnt_a(0), r);
        s = ic[0];
        repeat (10) @(posedge hclk);
        rd(cnt_a(0), r2);
        `CHK(r2, r)
        `CHK(ic[0], s)
        $display("running write test done");
    endtask : t_run
    task automatic t_event;
        logic [31:0] r;
        logic [15:0] s, s2;
        w(mode_a(1), 32'h01);
        w(mode_a(2), 32'h09);
        w(A_UD, 32'h2);
        w(cnt_a(1), 32'hfffd);
        w(cnt_a(2), 32'h0);
        s = ic[1];
        s2 = ic[2];
        w(A_START, 32'h6);
        fire(4'h6);
        `CHK(ic[1] - s, 16'h2)
        `CHK(ic[2] - s2, 16'h2)
        w(A_START, 32'h0);
        w(A_UD, 32'h0);
        w(cnt_a(1), 32'h1);
        s = ic[1];
        w(A_START, 32'h2);
        fire(4'h6);
        `CHK(ic[1] - s, 16'h3)
        w(A_START, 32'h0);
        w(mode_a(1), 32'h21);
        w(A_UD, 32'h2);
        w(cnt_a(1), 32'hfffe);
        w(A_START, 32'h2);
        fire(4'h3);
        rd(cnt_a(1), r);
        `CHK(r, 32'h1)
        w(A_START, 32'h0);
        $display("event test done");
    endtask : t_event
    task automatic t_pin;
        logic [31:0] r;
        logic        p;
        int          k;
        w(mode_a(2), 32'h04);
        w(cnt_a(2), 32'h3);
        w(A_START, 32'h4);
        wait_irq(2, k);
        p = o2;
        wait_irq(2, k);
        `CHK(o2, ~p)
        `CHK(oe2, 1'b1)
        w(A_START, 32'h0);
        w(mode_a(2), 32'h0);
        w(A_PORT, 32'h5);
        repeat (4) @(posedge hclk);
        `CHK({oe2, o2}, 2'h3)
        `CHK({oe3, o3}, 2'h0)
        w(A_PORT, 32'h0);
        dir_lvl <= 1'b1;
        repeat (6) @(posedge hclk);
        rd(A_PORT, r);
        `CHK(r, 32'h30)
        // Pin level says up while the software flag says down
        w(mode_a(2), 32'h41);
        w(cnt_a(2), 32'hfffe);
        w(A_START, 32'h4);
        fire(4'h1);
        rd(cnt_a(2), r);
        `CHK(r, 32'hffff)
        `CHK(oe2, 1'b0)
        w(A_START, 32'h0);
        rd(32'hfc, r);
        `CHK(r, 32'h0)
        $display("pin test done");
    endtask : t_pin
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_interval;
        t_run;
        t_event;
        t_pin;
        wrap_up;
    end
endmodule : crtu_top_tb
bind crtu_top crtu_chk i_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hrdata, .hresp, .channel_two_output_pin_o, .channel_two_output_pin_oe,
    .channel_three_output_pin_o, .channel_three_output_pin_oe, .channel_irq);
